/* File: rtl/ebt_pkg.sv */
// Package: constants, types and register map for the break and bus-timeout block
package ebt_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] CMD_OFF = 8'h04;
  localparam logic [7:0] STAT_OFF = 8'h08;
  localparam logic [7:0] PTR_OFF = 8'h0C;
  localparam logic [7:0] MATCH_OFF = 8'h10;

  // ==========================================================================
  // Field positions
  localparam int CTRL_EXEC_BIT = 0;
  localparam int CTRL_TMO_BIT = 1;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_BRKEN_BIT = 1;
  localparam int STAT_HALT_BIT = 2;
  localparam int STAT_TMO_BIT = 3;
  localparam int STAT_GRP_LSB = 8;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Command codes written to CMD
  localparam logic [2:0] CMD_RUN = 3'h1;
  localparam logic [2:0] CMD_RUN_BRK = 3'h2;
  localparam logic [2:0] CMD_VEC_BRK = 3'h3;
  localparam logic [2:0] CMD_VEC_NOBRK = 3'h4;
  localparam logic [2:0] CMD_PEEK = 3'h5;

  // ==========================================================================
  // Timing
  localparam longint CLK_HZ = 20_000_000;
  localparam longint TMO_TIME_MS = 1000;
  localparam longint TMO_CYCLES = (TMO_TIME_MS * CLK_HZ) / 1000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Target bus sample
  typedef struct packed {
    logic cycle_start;
    logic fetch;
    logic exec;
    logic [19:0] addr;
  } ebt_bus_s;

  typedef enum logic [2:0] {
    ST_PAUSE = 3'b001,
    ST_RUN = 3'b010,
    ST_PEEK = 3'b100
  } ebt_mode_e;

endpackage : ebt_pkg

/* File: rtl/ebt_addr_match.sv */
// Address comparator with fetch or execute qualification
module ebt_addr_match #(
  parameter int AW = 20
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Setup
  input wire logic exec_only_i,
  input wire logic [AW-1:0] match_addr_i,
  // Bus observation
  input wire logic [AW-1:0] addr_i,
  input wire logic fetch_i,
  input wire logic exec_i,
  // Hit
  output logic hit_o
);

  initial begin
    if (AW < 1 || AW > 32) $error("ebt_addr_match: AW out of range");
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hit_o <= 1'b0;
    end else if (exec_only_i) begin
      hit_o <= exec_i && (addr_i == match_addr_i);
    end else begin
      hit_o <= (fetch_i || exec_i) && (addr_i == match_addr_i);
    end
  end

endmodule : ebt_addr_match

/* File: rtl/ebt_timeout.sv */
// Bus wait counter that flags a stalled cycle
module ebt_timeout #(
  parameter longint LIMIT = 20_000_000
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic enable_i,
  input wire logic cycle_start_i,
  input wire logic waiting_i,
  // Result
  output logic expire_o
);

  localparam int CW = $clog2(LIMIT + 1);
  logic [CW-1:0] count_q;

  initial begin
    if (LIMIT < 2) $error("ebt_timeout: LIMIT too small");
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_q <= '0;
    end else if (cycle_start_i || !enable_i || !waiting_i) begin
      count_q <= '0;
    end else if (count_q != CW'(LIMIT)) begin
      count_q <= count_q + CW'(1);
    end
  end

  assign expire_o = enable_i && waiting_i && (count_q == CW'(LIMIT - 1));

endmodule : ebt_timeout

/* File: rtl/ebt_break_ctrl.sv */
// Emulator break control and bus timeout, AXI4-Lite register slave
//
// Register access over AXI4-Lite and the address map were decided locally.
module ebt_break_ctrl #(
  parameter longint TMO_CYCLES = ebt_pkg::TMO_CYCLES,
  parameter int GW = 3
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [7:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  // Target bus
  input wire ebt_pkg::ebt_bus_s bus_i,
  input wire logic [31:0] code_pointer_i,
  input wire logic async_ready_input_i,
  input wire logic sync_ready_input_i,
  input wire logic clause_met_i,
  input wire logic [GW-1:0] event_group_i,
  // Ready override and emulation control
  output logic sync_ready_o,
  output logic sync_ready_oe_o,
  output logic halt_emulation_action_o,
  output logic group_restart_o,
  output logic running_o
);

  initial begin
    if (GW < 1 || GW > 8) $error("ebt_break_ctrl: GW out of range");
  end

  // ==========================================================================
  // Bus slave handshake
  logic aw_q, w_q, bvalid_q, rvalid_q, wstrb0_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_fire;
  assign s_awready_o = !aw_q && !bvalid_q;
  assign s_wready_o = !w_q && !bvalid_q;
  assign s_arready_o = !rvalid_q;
  assign s_bvalid_o = bvalid_q;
  assign s_bresp_o = bresp_q;
  assign s_rvalid_o = rvalid_q;
  assign s_rdata_o = rdata_q;
  assign s_rresp_o = rresp_q;
  assign wr_fire = aw_q && w_q && !bvalid_q;

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_q <= 1'b1;
        awaddr_q <= s_awaddr_i;
      end else if (wr_fire) begin
        aw_q <= 1'b0;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_q <= 1'b1;
        wdata_q <= s_wdata_i;
        wstrb0_q <= s_wstrb_i[0];
      end else if (wr_fire) begin
        w_q <= 1'b0;
      end
    end
  end
  logic wr_known;
  assign wr_known = awaddr_q == ebt_pkg::CTRL_OFF || awaddr_q == ebt_pkg::CMD_OFF ||
                    awaddr_q == ebt_pkg::MATCH_OFF;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= ebt_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_known ? ebt_pkg::RESP_OKAY : ebt_pkg::RESP_SLVERR;
    end else if (s_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Switches, command and match address
  logic exec_sw_q, bus_timeout_switch_q;
  logic [19:0] match_q;
  logic cmd_wr;
  logic [2:0] cmd;
  assign cmd_wr = wr_fire && awaddr_q == ebt_pkg::CMD_OFF && wstrb0_q;
  assign cmd = wdata_q[2:0];
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      exec_sw_q <= ebt_pkg::CTRL_RESET[ebt_pkg::CTRL_EXEC_BIT];
      bus_timeout_switch_q <= ebt_pkg::CTRL_RESET[ebt_pkg::CTRL_TMO_BIT];
      match_q <= 20'h00000;
    end else if (wr_fire && awaddr_q == ebt_pkg::CTRL_OFF) begin
      exec_sw_q <= wdata_q[ebt_pkg::CTRL_EXEC_BIT];
      bus_timeout_switch_q <= wdata_q[ebt_pkg::CTRL_TMO_BIT];
    end else if (wr_fire && awaddr_q == ebt_pkg::MATCH_OFF) begin
      match_q <= wdata_q[19:0];
    end
  end

  // ==========================================================================
  // Address match and timeout
  logic addr_hit, expire;
  logic waiting_q;
  ebt_addr_match #(
    .AW(20)
  ) u_match (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .exec_only_i(exec_sw_q),
    .match_addr_i(match_q),
    .addr_i(bus_i.addr),
    .fetch_i(bus_i.fetch),
    .exec_i(bus_i.exec),
    .hit_o(addr_hit)
  );
  ebt_pkg::ebt_mode_e mode_q;
  // A cycle waits from its start until the async, sync or forced ready arrives
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      waiting_q <= 1'b0;
    end else if (async_ready_input_i || sync_ready_input_i || sync_ready_o) begin
      waiting_q <= 1'b0;
    end else if (bus_i.cycle_start) begin
      waiting_q <= 1'b1;
    end
  end

  ebt_timeout #(
    .LIMIT(TMO_CYCLES)
  ) u_tmo (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .enable_i(bus_timeout_switch_q),
    .cycle_start_i(bus_i.cycle_start),
    .waiting_i(waiting_q && mode_q != ebt_pkg::ST_PAUSE),
    .expire_o(expire)
  );
  // Forced ready: one cycle, only when timeout is enabled
  logic force_q;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      force_q <= 1'b0;
    end else begin
      force_q <= expire && bus_timeout_switch_q;
    end
  end
  assign sync_ready_o = force_q && bus_timeout_switch_q;
  assign sync_ready_oe_o = force_q && bus_timeout_switch_q;

  // ==========================================================================
  // Run mode and break enable
  logic brk_en_q, halt_q, tmo_flag_q, restart_q;
  logic tmo_break_q;
  logic brk_now;
  assign brk_now = mode_q == ebt_pkg::ST_RUN &&
                   ((brk_en_q && (clause_met_i || addr_hit)) || tmo_break_q);
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tmo_break_q <= 1'b0;
    end else begin
      tmo_break_q <= force_q && mode_q == ebt_pkg::ST_RUN;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_q <= ebt_pkg::ST_PAUSE;
      brk_en_q <= 1'b0;
      restart_q <= 1'b0;
    end else begin
      restart_q <= 1'b0;
      unique case (mode_q)
        ebt_pkg::ST_PAUSE: begin
          if (cmd_wr && cmd == ebt_pkg::CMD_PEEK) begin
            mode_q <= ebt_pkg::ST_PEEK;
          end else if (cmd_wr && cmd inside {ebt_pkg::CMD_RUN, ebt_pkg::CMD_RUN_BRK,
                       ebt_pkg::CMD_VEC_BRK, ebt_pkg::CMD_VEC_NOBRK}) begin
            mode_q <= ebt_pkg::ST_RUN;
            restart_q <= 1'b1;
            brk_en_q <= cmd == ebt_pkg::CMD_RUN_BRK || cmd == ebt_pkg::CMD_VEC_BRK;
          end
        end
        ebt_pkg::ST_RUN: begin
          if (brk_now) begin
            mode_q <= ebt_pkg::ST_PAUSE;
          end else if (cmd_wr && (cmd == ebt_pkg::CMD_RUN_BRK ||
                                  cmd == ebt_pkg::CMD_VEC_BRK)) begin
            brk_en_q <= 1'b1;
          end else if (cmd_wr && (cmd == ebt_pkg::CMD_RUN ||
                                  cmd == ebt_pkg::CMD_VEC_NOBRK)) begin
            brk_en_q <= 1'b0;
          end
        end
        ebt_pkg::ST_PEEK: begin
          if (sync_ready_o || async_ready_input_i || sync_ready_input_i) begin
            mode_q <= ebt_pkg::ST_PAUSE;
          end
        end
        default: begin
          mode_q <= ebt_pkg::ST_PAUSE;
        end
      endcase
    end
  end

  // Break report: code pointer and event group captured at the break
  logic [31:0] ptr_q;
  logic [GW-1:0] grp_q;
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ptr_q <= 32'h0000_0000;
      grp_q <= '0;
      halt_q <= 1'b0;
      tmo_flag_q <= 1'b0;
    end else if (brk_now) begin
      ptr_q <= code_pointer_i;
      grp_q <= event_group_i;
      halt_q <= 1'b1;
      tmo_flag_q <= tmo_break_q;
    end else if (restart_q) begin
      halt_q <= 1'b0;
      tmo_flag_q <= 1'b0;
    end
  end

  assign halt_emulation_action_o = halt_q;
  assign group_restart_o = restart_q;
  assign running_o = mode_q == ebt_pkg::ST_RUN;
  // ==========================================================================
  // Read channel
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    unique case (s_araddr_i)
      ebt_pkg::CTRL_OFF: begin
        rd_val[ebt_pkg::CTRL_EXEC_BIT] = exec_sw_q;
        rd_val[ebt_pkg::CTRL_TMO_BIT] = bus_timeout_switch_q;
      end
      ebt_pkg::STAT_OFF: begin
        rd_val[ebt_pkg::STAT_RUN_BIT] = running_o;
        rd_val[ebt_pkg::STAT_BRKEN_BIT] = brk_en_q;
        rd_val[ebt_pkg::STAT_HALT_BIT] = halt_q;
        rd_val[ebt_pkg::STAT_TMO_BIT] = tmo_flag_q;
        rd_val[ebt_pkg::STAT_GRP_LSB +: GW] = grp_q;
      end
      ebt_pkg::PTR_OFF: rd_val = ptr_q;
      ebt_pkg::MATCH_OFF: rd_val[19:0] = match_q;
      ebt_pkg::CMD_OFF: rd_val = 32'h0000_0000;
      default: rd_ok = 1'b0;
    endcase
  end
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= ebt_pkg::RESP_OKAY;
    end else if (s_arvalid_i && s_arready_o) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_ok ? ebt_pkg::RESP_OKAY : ebt_pkg::RESP_SLVERR;
    end else if (s_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  ready_quiet_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !bus_timeout_switch_q |-> !sync_ready_oe_o) else $error("ready driven while off");
  tmo_force_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    expire && bus_timeout_switch_q |=> sync_ready_o || !bus_timeout_switch_q)
    else $error("no forced ready after timeout");
  sequence run_tmo_s;
    sync_ready_o && mode_q == ebt_pkg::ST_RUN;
  endsequence
  tmo_break_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    run_tmo_s |=> ##1 mode_q == ebt_pkg::ST_PAUSE) else $error("timeout did not break");
  peek_nobrk_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    mode_q == ebt_pkg::ST_PEEK |=> !$rose(halt_q) &&
    (!$past(sync_ready_o) || mode_q == ebt_pkg::ST_PAUSE)) else $error("break during peek");
  brk_stop_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    brk_now |=> mode_q == ebt_pkg::ST_PAUSE && halt_q) else $error("break did not pause");
  brk_report_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    brk_now |=> ptr_q == $past(code_pointer_i)) else $error("pointer not captured");
  run_enable_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    cmd_wr && cmd == ebt_pkg::CMD_RUN_BRK && !brk_now && mode_q != ebt_pkg::ST_PEEK
    |=> brk_en_q && running_o) else $error("run with breaks failed");
  run_disable_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    cmd_wr && cmd == ebt_pkg::CMD_RUN && !brk_now && mode_q != ebt_pkg::ST_PEEK
    |=> !brk_en_q && running_o) else $error("plain run failed");
  restart_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $rose(running_o) |-> group_restart_o) else $error("no group restart");
  exec_hit_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    exec_sw_q && $stable(exec_sw_q) && !$past(bus_i.exec) |-> !addr_hit)
    else $error("prefetch hit with exec switch");
endmodule : ebt_break_ctrl

/* File: verif/ebt_target_model.sv */
// Target bus model: opens bus cycles on request and answers ready after a set wait
module ebt_target_model (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Requests from the bench
  input wire logic go_i,
  input wire logic exec_i,
  input wire logic [19:0] addr_i,
  input wire logic [7:0] wait_i,
  input wire logic forced_ready_i,
  // Target bus
  output ebt_pkg::ebt_bus_s bus_o,
  output logic async_ready_o,
  output logic sync_ready_o,
  output logic busy_o
);
  logic [7:0] cnt_q;
  logic [7:0] wait_q;

  // ==========================================================================
  // Cycle sequencing: odd waits answer on the async line, even ones on sync
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bus_o <= '0;
      cnt_q <= 8'h00;
      wait_q <= 8'h00;
      async_ready_o <= 1'h0;
      sync_ready_o <= 1'h0;
      busy_o <= 1'h0;
    end else if (go_i && !busy_o) begin
      bus_o <= '{1'h1, !exec_i, exec_i, addr_i};
      cnt_q <= 8'h00;
      wait_q <= wait_i;
      busy_o <= 1'h1;
    end else begin
      bus_o.cycle_start <= 1'h0;
      bus_o.fetch <= 1'h0;
      bus_o.exec <= 1'h0;
      async_ready_o <= 1'h0;
      sync_ready_o <= 1'h0;
      if (busy_o) begin
        cnt_q <= cnt_q + 8'h01;
        // Released address lines show a changed pattern
        if (forced_ready_i || async_ready_o || sync_ready_o) begin
          busy_o <= 1'h0;
          bus_o.addr <= ~bus_o.addr;
        end else if (cnt_q == wait_q) begin
          async_ready_o <= wait_q[0];
          sync_ready_o <= !wait_q[0];
        end
      end
    end
  end
endmodule : ebt_target_model

/* File: verif/ebt_break_ctrl_tb.sv */
// Testbench for the break control and bus timeout block
module ebt_break_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam longint TMO = 16;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, wr_resp;
  logic [31:0] rdata;
  logic [31:0] cp = 32'h0;
  logic [2:0] grp = 3'h0;
  logic clause_met = 1'h0;
  logic go = 1'h0;
  logic gexec = 1'h0;
  logic [19:0] gaddr = 20'h0;
  logic [7:0] gwait = 8'h0;
  ebt_pkg::ebt_bus_s bus;
  logic async_ready_input, sync_ready_input_t, sync_ready_input_w, sr_o, sr_oe, halt, grst, run, busy;
  logic sr_run = 1'h0;
  int fail_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int sr_cnt = 0;
  int gr_cnt = 0;
  logic [2:0] row_cmd [4] = '{ebt_pkg::CMD_RUN, ebt_pkg::CMD_RUN_BRK, ebt_pkg::CMD_VEC_BRK,
    ebt_pkg::CMD_VEC_NOBRK};
  logic row_en [4] = '{1'h0, 1'h1, 1'h1, 1'h0};

  always #25 clk = ~clk;
  assign sync_ready_input_w = sync_ready_input_t | (sr_oe & sr_o);

  // Counts forced ready pulses and group restarts
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (sr_oe || sr_o) begin
      chk_bit(sr_oe, sr_o);
      sr_cnt <= sr_cnt + 1;
      sr_run <= run;
    end
    if (grst) begin
      gr_cnt <= gr_cnt + 1;
    end
  end

  ebt_break_ctrl #(.TMO_CYCLES(TMO), .GW(3)) uut (
    .clock_i(clk), .sys_rst_i(rst),
    .s_awaddr_i(awaddr), .s_awvalid_i(awvalid), .s_awready_o(awready),
    .s_wdata_i(wdata), .s_wstrb_i(4'hF), .s_wvalid_i(wvalid), .s_wready_o(wready),
    .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
    .s_araddr_i(araddr), .s_arvalid_i(arvalid), .s_arready_o(arready),
    .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid), .s_rready_i(rready),
    .bus_i(bus), .code_pointer_i(cp), .async_ready_input_i(async_ready_input),
    .sync_ready_input_i(sync_ready_input_w), .clause_met_i(clause_met), .event_group_i(grp),
    .sync_ready_o(sr_o), .sync_ready_oe_o(sr_oe), .halt_emulation_action_o(halt),
    .group_restart_o(grst), .running_o(run)
  );

  ebt_target_model tgt (
    .clock_i(clk), .sys_rst_i(rst), .go_i(go), .exec_i(gexec), .addr_i(gaddr),
    .wait_i(gwait), .forced_ready_i(sr_oe & sr_o), .bus_o(bus),
    .async_ready_o(async_ready_input), .sync_ready_o(sync_ready_input_t), .busy_o(busy)
  );

  // ==========================================================================
  // Tasks
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    wr_resp = bresp;
    bready <= 1'h0;
    @(posedge clk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge clk);
  endtask : axi_read

  task automatic run_cmd(input logic [2:0] c);
    axi_write(ebt_pkg::CMD_OFF, {29'h0, c});
    step(2);
  endtask : run_cmd

  task automatic clause(input logic [31:0] p, input logic [2:0] g);
    cp <= p;
    grp <= g;
    clause_met <= 1'h1;
    @(posedge clk);
    clause_met <= 1'h0;
    step(4);
  endtask : clause

  task automatic bus_cyc(input logic [19:0] a, input logic x, input logic [7:0] w);
    gaddr <= a;
    gexec <= x;
    gwait <= w;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    repeat (300) begin
      @(posedge clk);
      if (!busy) break;
    end
    step(4);
  endtask : bus_cyc

  task automatic print_verdict();
    if (fail_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int s;
    int t;
    step(20);
    rst <= 1'h0;
    @(posedge clk);
    axi_read(ebt_pkg::CTRL_OFF, d, r);
    chk_word(d, ebt_pkg::CTRL_RESET);
    axi_read(8'h3C, d, r);
    chk_word({30'h0, r}, {30'h0, ebt_pkg::RESP_SLVERR});
    axi_write(8'h3C, 32'h0000_0001);
    chk_word({30'h0, wr_resp}, {30'h0, ebt_pkg::RESP_SLVERR});
    // Stalled peek cycle
    axi_write(ebt_pkg::CTRL_OFF, 32'h0000_0002);
    chk_word({30'h0, wr_resp}, {30'h0, ebt_pkg::RESP_OKAY});
    axi_read(ebt_pkg::CTRL_OFF, d, r);
    chk_word(d, 32'h0000_0002);
    run_cmd(ebt_pkg::CMD_PEEK);
    s = sr_cnt;
    bus_cyc(20'h00100, 1'h0, 8'hFF);
    chk_word(32'(sr_cnt - s), 32'h1);
    chk_bit(halt, 1'h0);
    chk_bit(run, 1'h0);
    // Run commands table
    for (int i = 0; i < 4; i++) begin
      s = gr_cnt;
      run_cmd(row_cmd[i]);
      chk_bit(run, 1'h1);
      chk_word(32'(gr_cnt - s), 32'h1);
      axi_read(ebt_pkg::STAT_OFF, d, r);
      chk_bit(d[ebt_pkg::STAT_BRKEN_BIT], row_en[i]);
      clause(32'h0000_1000 + i, 3'(i + 1));
      chk_bit(run, !row_en[i]);
      if (!row_en[i]) begin
        run_cmd(ebt_pkg::CMD_RUN_BRK);
        chk_bit(run, 1'h1);
        clause(32'h0000_1000 + i, 3'(i + 1));
        chk_bit(run, 1'h0);
      end
      chk_bit(halt, 1'h1);
      axi_read(ebt_pkg::PTR_OFF, d, r);
      chk_word(d, 32'h0000_1000 + i);
      axi_read(ebt_pkg::STAT_OFF, d, r);
      chk_word({29'h0, d[10:8]}, 32'(i + 1));
    end
    // Disable breaks while running
    run_cmd(ebt_pkg::CMD_RUN_BRK);
    run_cmd(ebt_pkg::CMD_RUN);
    axi_read(ebt_pkg::STAT_OFF, d, r);
    chk_bit(d[ebt_pkg::STAT_BRKEN_BIT], 1'h0);
    clause(32'h0000_2222, 3'h2);
    chk_bit(run, 1'h1);
    // Address breaks on fetch and execute
    axi_write(ebt_pkg::MATCH_OFF, 32'h0001_2344);
    axi_write(ebt_pkg::CTRL_OFF, 32'h0000_0001);
    run_cmd(ebt_pkg::CMD_RUN_BRK);
    bus_cyc(20'h12344, 1'h0, 8'h02);
    chk_bit(run, 1'h1);
    bus_cyc(20'h12344, 1'h1, 8'h03);
    chk_bit(run, 1'h0);
    axi_write(ebt_pkg::CTRL_OFF, 32'h0000_0000);
    run_cmd(ebt_pkg::CMD_RUN_BRK);
    bus_cyc(20'h12348, 1'h0, 8'h02);
    chk_bit(run, 1'h1);
    bus_cyc(20'h12344, 1'h0, 8'h02);
    chk_bit(run, 1'h0);
    // Timeout in run mode
    axi_write(ebt_pkg::CTRL_OFF, 32'h0000_0002);
    run_cmd(ebt_pkg::CMD_RUN_BRK);
    s = sr_cnt;
    bus_cyc(20'h00200, 1'h0, 8'(TMO - 4));
    bus_cyc(20'h00204, 1'h1, 8'(TMO - 3));
    chk_word(32'(sr_cnt - s), 32'h0);
    t = cyc;
    bus_cyc(20'h00208, 1'h0, 8'hFF);
    t = cyc - t;
    chk_bit(t >= TMO && t <= TMO + 12, 1'h1);
    chk_word(32'(sr_cnt - s), 32'h1);
    chk_bit(sr_run, 1'h1);
    chk_bit(run, 1'h0);
    axi_read(ebt_pkg::STAT_OFF, d, r);
    chk_bit(d[ebt_pkg::STAT_TMO_BIT], 1'h1);
    // Timeout switched off
    axi_write(ebt_pkg::CTRL_OFF, 32'h0000_0000);
    run_cmd(ebt_pkg::CMD_RUN);
    s = sr_cnt;
    bus_cyc(20'h00300, 1'h0, 8'hFF);
    chk_word(32'(sr_cnt - s), 32'h0);
    chk_bit(run, 1'h1);
    print_verdict();
  end
endmodule : ebt_break_ctrl_tb
